// file: rtl/rsq_pkg.sv
package rsq_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 10;
    localparam int PWR_STABLE_US = 10;
    localparam int RC_WARM_US = 16;
    localparam int XTAL_WARM_US = 400;
    localparam int WDT_TICK_US = 10;
    localparam int PWR_STABLE_CYC = PWR_STABLE_US * CLK_MHZ;
    localparam int RC_WARM_CYC = RC_WARM_US * CLK_MHZ;
    localparam int XTAL_WARM_CYC = XTAL_WARM_US * CLK_MHZ;
    localparam int WDT_TICK_CYC = WDT_TICK_US * CLK_MHZ;

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_PROGRAM_STATUS_FLAGS = 10'h086;
    localparam logic [9:0] IDX_CTRL = 10'h090;
    localparam logic [9:0] IDX_WDT = 10'h091;
    localparam logic [9:0] IDX_STAT = 10'h092;
    localparam logic [9:0] IDX_MASK = 10'h093;
    localparam logic [9:0] IDX_SEQ = 10'h094;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int PF_CAUSE_LSB = 6;
    localparam int CTRL_PIN_EN = 0;
    localparam int CTRL_XTAL = 1;
    localparam int CTRL_WDT_EN = 2;
    localparam logic [2:0] CTRL_RESET = 3'h5;
    localparam int EV_DONE = 0;
    localparam int EV_PWR = 1;
    localparam int EV_PIN = 2;
    localparam int EV_WDT = 3;
    localparam logic [1:0] CAUSE_WDT = 2'h0;
    localparam logic [1:0] CAUSE_PWR = 2'h2;
    localparam logic [1:0] CAUSE_PIN = 2'h3;
    localparam logic [13:0] RESET_VECTOR_ORIGIN = 14'h0000;
    localparam logic [7:0] WDT_LAST = 8'hff;

    typedef enum logic [4:0] {
        SQ_POWER_UP = 5'b00001,
        SQ_PIN_CHECK = 5'b00010,
        SQ_INIT = 5'b00100,
        SQ_WARMUP = 5'b01000,
        SQ_RUN = 5'b10000
    } rsq_state_t;

    typedef struct packed {
        logic hold;
        logic pc_clear;
        logic reg_init;
        logic exec_start;
    } rsq_core_t;

    typedef struct packed {
        logic pin_n;
        logic lvd_low;
        logic supply_ok;
    } rsq_src_t;

endpackage

// file: rtl/rsq_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - any source starts a reset sequence
// - during reset hold registers, stop, clear pc
// - after release execute from address zero
// - cause readable in two flag bits
// - cause code 00 wdt, 10 power, 11 pin
// - power-up waits for stable supply
// - enabled pin low keeps device in reset
// - init, then oscillator warm-up, then execute
// - warm-up short for rc, long for crystal
// - watchdog overflow resets the system
// - watchdog counts until overflow unless cleared
// - after watchdog reset return to normal run
// - low-voltage detection resets the system
// - reset pin active low when option enabled
module rsq_sequencer
    import rsq_pkg::*;
(
    input wire logic clock, // 10 MHz system clock
    input wire logic rstn, // power-on reset, active low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [11:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic wb_ack_o, // wishbone acknowledge
    output logic [31:0] wb_dat_o, // wishbone read data
    input wire logic supply_ok_pin, // supply monitor: supply up
    input wire logic low_voltage_detector, // high when below level
    input wire logic ext_reset_pin_n, // external reset pin
    output rsq_core_t core_o, // core reset controls
    output logic [13:0] pc_vector, // start address for the core
    output logic irq // level interrupt
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    rsq_src_t src;
    rsq_sync #(.WIDTH(3), .RESET_VAL(3'h4)) rsq_sync_inst (
        .clock(clock),
        .rstn(rstn),
        .d({ext_reset_pin_n, low_voltage_detector, supply_ok_pin}),
        .q(src)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [9:0] idx;
    logic bus_req, bus_wr;
    logic wr_program_status_flags, wr_ctrl, wr_wdt, wr_stat, wr_mask;
    logic [7:0] wdat;

    assign idx = wb_adr_i[11:2];
    // single-cycle ack; ack low in the cycle after it was given
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign wdat = wb_dat_i[7:0];
    assign wr_program_status_flags = bus_wr && (idx == IDX_PROGRAM_STATUS_FLAGS);
    assign wr_ctrl = bus_wr && (idx == IDX_CTRL);
    assign wr_wdt = bus_wr && (idx == IDX_WDT) && wdat[0];
    assign wr_stat = bus_wr && (idx == IDX_STAT);
    assign wr_mask = bus_wr && (idx == IDX_MASK);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rsq_state_t state, next_state;
    logic [12:0] seq_cnt, next_seq_cnt;
    logic [1:0] reset_cause, next_reset_cause;
    rsq_core_t next_core;
    logic [9:0] wdt_div, next_wdt_div;
    logic [7:0] wdt_cnt, next_wdt_cnt;
    logic [2:0] ctrl, next_ctrl;
    logic [3:0] status, next_status;
    logic [3:0] mask, next_mask;
    logic [2:0] program_status_flags_low, next_program_status_flags_low;
    logic next_ack, next_irq;
    logic [31:0] next_dat;
    logic [3:0] ev;
    logic pwr_req, pin_req, wdt_run, wdt_tick, wdt_ovf;
    logic [12:0] warm_last;

    // supply and detector share one request; the pin has its own
    assign pwr_req = !src.supply_ok || src.lvd_low;
    assign pin_req = ctrl[CTRL_PIN_EN] && !src.pin_n;
    assign warm_last = ctrl[CTRL_XTAL] ? 13'(XTAL_WARM_CYC - 1)
                                       : 13'(RC_WARM_CYC - 1);

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    assign wdt_run = (state == SQ_RUN) && ctrl[CTRL_WDT_EN];
    assign wdt_tick = wdt_run && (wdt_div == 10'(WDT_TICK_CYC - 1));
    assign wdt_ovf = wdt_tick && (wdt_cnt == WDT_LAST);

    always_comb begin
        next_wdt_div = wdt_div;
        next_wdt_cnt = wdt_cnt;
        if (!wdt_run || wr_wdt) begin
            // clearing also restarts the prescaler, so a clear
            // buys one full period, except in the overflow cycle itself
            next_wdt_div = '0;
            next_wdt_cnt = '0;
        end else if (wdt_tick) begin
            next_wdt_div = '0;
            next_wdt_cnt = wdt_cnt + 8'h01;
        end else begin
            next_wdt_div = wdt_div + 10'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            wdt_div <= '0;
            wdt_cnt <= '0;
        end else begin
            wdt_div <= next_wdt_div;
            wdt_cnt <= next_wdt_cnt;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_seq_cnt = seq_cnt;
        next_reset_cause = reset_cause;
        ev = '0;
        if (wr_program_status_flags) begin
            next_reset_cause = wdat[7:6];
        end
        case (state)
            SQ_POWER_UP: begin
                if (pwr_req) begin
                    next_seq_cnt = '0;
                end else if (seq_cnt == 13'(PWR_STABLE_CYC - 1)) begin
                    next_state = SQ_PIN_CHECK;
                    next_seq_cnt = '0;
                end else begin
                    next_seq_cnt = seq_cnt + 13'h0001;
                end
            end
            SQ_PIN_CHECK: begin
                if (!pin_req) begin
                    next_state = SQ_INIT;
                end
            end
            SQ_INIT: begin
                next_state = SQ_WARMUP;
                next_seq_cnt = '0;
            end
            SQ_WARMUP: begin
                if (seq_cnt == warm_last) begin
                    next_state = SQ_RUN;
                    ev[EV_DONE] = 1'b1;
                end else begin
                    next_seq_cnt = seq_cnt + 13'h0001;
                end
            end
            SQ_RUN: begin
                if (wdt_ovf) begin
                    // watchdog skips supply and pin checks
                    next_state = SQ_INIT;
                    next_reset_cause = CAUSE_WDT;
                    ev[EV_WDT] = 1'b1;
                end
            end
            default: begin
                next_state = SQ_POWER_UP;
                next_seq_cnt = '0;
            end
        endcase
        // supply loss outranks the pin, the pin outranks the watchdog
        if (pwr_req && state != SQ_POWER_UP) begin
            next_state = SQ_POWER_UP;
            next_seq_cnt = '0;
            next_reset_cause = CAUSE_PWR;
            ev[EV_PWR] = 1'b1;
            ev[EV_DONE] = 1'b0;
            ev[EV_WDT] = 1'b0;
        end else if (pin_req && (state == SQ_INIT || state == SQ_WARMUP
                                 || state == SQ_RUN)) begin
            next_state = SQ_PIN_CHECK;
            next_seq_cnt = '0;
            ev[EV_DONE] = 1'b0;
            ev[EV_WDT] = 1'b0;
            if (state == SQ_RUN) begin
                next_reset_cause = CAUSE_PIN;
                ev[EV_PIN] = 1'b1;
            end
        end
        next_core.hold = (next_state != SQ_RUN);
        next_core.pc_clear = (next_state != SQ_RUN);
        next_core.reg_init = (next_state == SQ_INIT);
        next_core.exec_start = (state == SQ_WARMUP)
                               && (next_state == SQ_RUN);
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= SQ_POWER_UP;
            seq_cnt <= '0;
            reset_cause <= CAUSE_PWR;
            core_o <= 4'hc;
        end else begin
            state <= next_state;
            seq_cnt <= next_seq_cnt;
            reset_cause <= next_reset_cause;
            core_o <= next_core;
        end
    end

    // ------------------------------------------------------------
    // registers and bus answer
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl = wr_ctrl ? wdat[2:0] : ctrl;
        next_mask = wr_mask ? wdat[3:0] : mask;
        // a new event wins over a write-one clear in the same cycle
        next_status = (wr_stat ? (status & ~wdat[3:0]) : status) | ev;
        if (next_state != SQ_RUN) begin
            next_program_status_flags_low = '0;
        end else if (wr_program_status_flags) begin
            next_program_status_flags_low = wdat[2:0];
        end else begin
            next_program_status_flags_low = program_status_flags_low;
        end
        next_irq = |(next_status & next_mask);
        next_ack = bus_req;
        next_dat = '0;
        if (bus_req && !wb_we_i) begin
            case (idx)
                IDX_PROGRAM_STATUS_FLAGS: next_dat[7:0] = {reset_cause, 3'h0,
                                            program_status_flags_low};
                IDX_CTRL: next_dat[2:0] = ctrl;
                IDX_WDT: next_dat[7:0] = wdt_cnt;
                IDX_STAT: next_dat[3:0] = status;
                IDX_MASK: next_dat[3:0] = mask;
                IDX_SEQ: next_dat[4:0] = state;
                default: next_dat = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctrl <= CTRL_RESET;
            mask <= '0;
            status <= '0;
            program_status_flags_low <= '0;
            irq <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            pc_vector <= RESET_VECTOR_ORIGIN;
        end else begin
            ctrl <= next_ctrl;
            mask <= next_mask;
            status <= next_status;
            program_status_flags_low <= next_program_status_flags_low;
            irq <= next_irq;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
            pc_vector <= RESET_VECTOR_ORIGIN;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [12:0] warm_age;
    always_ff @(posedge clock) begin
        if (!rstn || state != SQ_WARMUP) begin
            warm_age <= '0;
        end else begin
            warm_age <= warm_age + 13'h0001;
        end
    end

    property p_any_source;
        @(posedge clock) disable iff (!rstn)
        (state == SQ_RUN && (pwr_req || pin_req || wdt_ovf))
            |=> (state != SQ_RUN && core_o.hold);
    endproperty
    a_any_source: assert property (p_any_source)
        else $error("reset source did not stop execution");
    property p_hold;
        @(posedge clock) disable iff (!rstn)
        (state != SQ_RUN) |-> (core_o.hold && core_o.pc_clear
                               && program_status_flags_low == 3'h0);
    endproperty
    a_hold: assert property (p_hold)
        else $error("core not held while in reset");
    property p_start;
        @(posedge clock) disable iff (!rstn)
        $rose(state == SQ_RUN) |-> (core_o.exec_start && !core_o.hold
                                   && pc_vector == 14'h0000)
                                   ##1 !core_o.exec_start;
    endproperty
    a_start: assert property (p_start)
        else $error("execution start wrong");
    property p_cause_pin;
        @(posedge clock) disable iff (!rstn)
        (state == SQ_RUN && pin_req && !pwr_req)
            |=> (reset_cause == 2'h3 && state == SQ_PIN_CHECK);
    endproperty
    a_cause_pin: assert property (p_cause_pin)
        else $error("pin reset cause not recorded");
    property p_power;
        @(posedge clock) disable iff (!rstn)
        (state != SQ_POWER_UP && pwr_req)
            |=> (reset_cause == 2'h2 && state == SQ_POWER_UP);
    endproperty
    a_power: assert property (p_power)
        else $error("low voltage did not restart power-up");
    property p_supply_wait;
        @(posedge clock) disable iff (!rstn)
        (state == SQ_POWER_UP && pwr_req) |=> (state == SQ_POWER_UP)
            ##0 (seq_cnt == 13'h0000);
    endproperty
    a_supply_wait: assert property (p_supply_wait)
        else $error("left power-up with supply not stable");
    property p_pin_wait;
        @(posedge clock) disable iff (!rstn)
        (state == SQ_PIN_CHECK && pin_req && !pwr_req)
            |=> (state == SQ_PIN_CHECK && core_o.hold);
    endproperty
    a_pin_wait: assert property (p_pin_wait)
        else $error("left pin check with pin low");
    property p_wdt_reset;
        @(posedge clock) disable iff (!rstn)
        (wdt_ovf && !pwr_req && !pin_req)
            |=> (state == SQ_INIT && reset_cause == 2'h0)
            ##1 (state == SQ_WARMUP);
    endproperty
    a_wdt_reset: assert property (p_wdt_reset)
        else $error("watchdog overflow did not reset");
    property p_wdt_count;
        @(posedge clock) disable iff (!rstn)
        (wdt_tick && !wr_wdt && wdt_cnt != 8'hff)
            |=> (wdt_cnt == $past(wdt_cnt) + 8'h01);
    endproperty
    a_wdt_count: assert property (p_wdt_count)
        else $error("watchdog did not count");
    property p_warm_len;
        @(posedge clock) disable iff (!rstn)
        (state == SQ_WARMUP) |-> (ctrl[1] ? warm_age < 13'd4000
                                          : warm_age < 13'd160);
    endproperty
    a_warm_len: assert property (p_warm_len)
        else $error("warm-up exceeded its length");
    property p_irq;
        @(posedge clock) disable iff (!rstn)
        (|(status & mask)) |-> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");
endmodule

// file: rtl/rsq_sync.sv
`timescale 1ns/1ps
module rsq_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock, // system clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic [WIDTH-1:0] d, // asynchronous inputs
    output logic [WIDTH-1:0] q // synchronised outputs
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            meta <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// file: testbench/rsq_sequencer_test.sv
`timescale 1ns/1ps
module rsq_sequencer_test
    import rsq_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic wb_ack_o, irq, supply_ok_pin, low_voltage_detector;
    logic ext_reset_pin_n;
    logic [31:0] wb_dat_o;
    logic [13:0] pc_vector;
    rsq_core_t core_o;
    logic power_on = 1'b0;
    logic brown_out = 1'b0;
    logic pin_press = 1'b0;
    int error_cnt = 0;
    int tests_run = 0;
    int n;
    logic [7:0] r;
    string exp_name[$];
    logic [31:0] exp_val[$];

    rsq_sequencer rsq_sequencer_inst (.clock(clock), .rstn(rstn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .supply_ok_pin(supply_ok_pin),
        .low_voltage_detector(low_voltage_detector),
        .ext_reset_pin_n(ext_reset_pin_n), .core_o(core_o),
        .pc_vector(pc_vector), .irq(irq));
    rsq_supply_model rsq_supply_model_inst (.clock(clock),
        .power_on(power_on), .brown_out(brown_out), .pin_press(pin_press),
        .supply_ok_pin(supply_ok_pin),
        .low_voltage_detector(low_voltage_detector),
        .ext_reset_pin_n(ext_reset_pin_n));

    initial forever #50 clock = ~clock;

    // ------------------------------------------------------------
    // checking and ending
    // ------------------------------------------------------------
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cycles(int k);
        repeat (k) @(negedge clock);
    endtask

    // ------------------------------------------------------------
    // bus master
    // ------------------------------------------------------------
    task automatic wb_cycle(logic w, logic [9:0] idx, logic [7:0] d,
                            logic [3:0] s);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        // ack is sampled at the rising edge; only the timeout ends a wait
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        // released at the edge that saw ack, so it is not taken twice
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wb_write(logic [9:0] idx, logic [7:0] d);
        wb_cycle(1'b1, idx, d, 4'h1);
    endtask

    task automatic wb_read(logic [9:0] idx, logic [31:0] e, string name);
        exp_name.push_back(name);
        exp_val.push_back(e);
        wb_cycle(1'b0, idx, 8'h00, 4'hf);
    endtask

    // read data stands only in the ack cycle
    always @(posedge clock) begin
        if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_val.size() == 0) begin
                check("unexpected_read", 0, 1);
            end else begin
                check(exp_name.pop_front(), wb_dat_o, exp_val.pop_front());
            end
        end
    end

    task automatic wait_hold(logic lvl, output int cnt);
        cnt = 0;
        while (core_o.hold !== lvl && cnt < 30000) begin
            @(negedge clock);
            cnt++;
        end
        if (cnt == 30000) check("hold_wait", 0, 1);
    endtask

    initial begin
        repeat (40000) @(posedge clock);
        check("timeout", 0, 1);
        stop_test();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'ha3d9));
        repeat (11) @(posedge clock);
        @(negedge clock);
        check("hold_in_reset", core_o.hold, 1);
        check("pc_clear_in_reset", core_o.pc_clear, 1);
        @(posedge clock);
        rstn <= 1'b1;
        wb_read(IDX_CTRL, {29'h0, CTRL_RESET}, "ctrl_reset");
        wb_read(IDX_MASK, 32'h0, "mask_reset");
        wb_read(10'h0ff, 32'h0, "unmapped_read");
        @(posedge clock);
        power_on <= 1'b1;
        pin_press <= 1'b1;
        cycles(80);
        wb_read(IDX_SEQ, 32'h1, "power_up_wait");
        cycles(300);
        check("hold_pin_low", core_o.hold, 1);
        wb_read(IDX_SEQ, 32'h2, "pin_check_wait");
        @(posedge clock);
        pin_press <= 1'b0;
        wait_hold(1'b0, n);
        check("exec_start", core_o.exec_start, 1);
        check("pc_vector", pc_vector, 32'(RESET_VECTOR_ORIGIN));
        n = n - RC_WARM_CYC;
        check("rc_warm", n >= 0 && n <= 10, 1);
        cycles(1);
        check("exec_pulse", core_o.exec_start, 0);
        // interrupt: masked, raised, cleared
        check("irq_masked", irq, 0);
        wb_read(IDX_PROGRAM_STATUS_FLAGS, {24'h0, CAUSE_PWR, 6'h0}, "cause_power");
        wb_write(IDX_MASK, 8'h01);
        cycles(3);
        check("irq_raised", irq, 1);
        wb_write(IDX_STAT, 8'h0f);
        cycles(3);
        check("irq_cleared", irq, 0);
        r = 8'($urandom());
        wb_write(IDX_PROGRAM_STATUS_FLAGS, r);
        wb_read(IDX_PROGRAM_STATUS_FLAGS, {24'h0, r[7:6], 3'h0, r[2:0]}, "program_status_flags_rw");
        wb_write(IDX_MASK, r);
        wb_read(IDX_MASK, {28'h0, r[3:0]}, "mask_rw");
        wb_write(IDX_MASK, 8'h04);
        wb_cycle(1'b1, IDX_MASK, ~r, 4'h0);
        wb_read(IDX_MASK, 32'h4, "mask_sel_ignored");
        wb_write(IDX_SEQ, r);
        wb_read(IDX_SEQ, 32'h10, "state_read_only");
        wb_write(10'h0ff, r);
        wb_read(10'h0ff, 32'h0, "unmapped_write");
        wb_write(IDX_WDT, 8'h01);
        wb_read(IDX_WDT, 32'h0, "wdt_cleared");
        // pin reset from running
        @(posedge clock);
        pin_press <= 1'b1;
        wait_hold(1'b1, n);
        check("pin_reset_fast", n <= 6, 1);
        check("pc_cleared", core_o.pc_clear, 1);
        cycles(20);
        @(posedge clock);
        pin_press <= 1'b0;
        wait_hold(1'b0, n);
        check("irq_pin", irq, 1);
        wb_read(IDX_PROGRAM_STATUS_FLAGS, {24'h0, CAUSE_PIN, 6'h0}, "cause_pin");
        wb_read(IDX_STAT, 32'h5, "status_pin");
        wb_write(IDX_STAT, 8'h0f);
        wb_write(IDX_CTRL, 8'h04);
        @(posedge clock);
        pin_press <= 1'b1;
        cycles(50);
        check("pin_disabled", core_o.hold, 0);
        @(posedge clock);
        pin_press <= 1'b0;
        // the synchronised pin lags; re-enabling it early would reset
        cycles(5);
        wb_write(IDX_CTRL, 8'h07);
        // brown-out with crystal warm-up
        @(posedge clock);
        brown_out <= 1'b1;
        wait_hold(1'b1, n);
        check("lvd_reset_fast", n <= 6, 1);
        cycles(20);
        @(posedge clock);
        brown_out <= 1'b0;
        wait_hold(1'b0, n);
        n = n - PWR_STABLE_CYC - XTAL_WARM_CYC;
        check("xtal_warm", n >= 0 && n <= 12, 1);
        wb_read(IDX_PROGRAM_STATUS_FLAGS, {24'h0, CAUSE_PWR, 6'h0}, "cause_lvd");
        wb_read(IDX_STAT, 32'h3, "status_lvd");
        // watchdog left unserviced: eight-bit count overflows on tick 256
        wb_write(IDX_CTRL, 8'h05);
        wb_write(IDX_STAT, 8'h0f);
        wb_write(IDX_WDT, 8'h01);
        wait_hold(1'b1, n);
        n = n - 256 * WDT_TICK_CYC;
        check("wdt_overflow", n >= -3 && n <= 3, 1);
        wait_hold(1'b0, n);
        n = n - RC_WARM_CYC;
        check("wdt_restart", n >= 0 && n <= 6, 1);
        wb_read(IDX_PROGRAM_STATUS_FLAGS, {24'h0, CAUSE_WDT, 6'h0}, "cause_wdt");
        wb_read(IDX_STAT, 32'h9, "status_wdt");
        cycles(5);
        stop_test();
    end
endmodule

// file: testbench/rsq_supply_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// far side: supply monitor, detector and reset pin
// ------------------------------------------------------------
module rsq_supply_model #(
    parameter int RAMP = 20
) (
    input wire logic clock, // system clock
    input wire logic power_on, // supply switched on
    input wire logic brown_out, // supply dipped below level
    input wire logic pin_press, // reset button held
    output logic supply_ok_pin, // supply up
    output logic low_voltage_detector, // below detect level
    output logic ext_reset_pin_n // reset pin, pulled up when free
);
    int ramp_cnt = 0;
    initial begin
        supply_ok_pin = 1'b0;
        low_voltage_detector = 1'b0;
        ext_reset_pin_n = 1'b1;
    end
    // supply ok lags power-on, as a real rail ramps slowly
    always @(posedge clock) begin
        if (!power_on) begin
            ramp_cnt <= 0;
        end else if (ramp_cnt < RAMP) begin
            ramp_cnt <= ramp_cnt + 1;
        end
        supply_ok_pin <= power_on && ramp_cnt == RAMP;
        low_voltage_detector <= brown_out;
        ext_reset_pin_n <= !pin_press;
    end
endmodule
